// >>> pth_pkg.sv
// package with register map, field layout and carriers for the proximity threshold and emitter registers
// Summary of operation
// - low nibble sets third emitter current
// - code zero off, one minimum, ones maximum
// - channel one threshold from offsets 0x11/0x12
// - channel two threshold low byte 0x13
// - threshold bytes used live, not double-buffered
// - older revisions use compressed 8-bit threshold
// - all threshold bytes reset to zero
`default_nettype none
package pth_pkg;
  // register offsets on the serial register port
  localparam logic [7:0] ADDR_LED3 = 8'h10;
  localparam logic [7:0] ADDR_P1_LO = 8'h11;
  localparam logic [7:0] ADDR_P1_HI = 8'h12;
  localparam logic [7:0] ADDR_P2_LO = 8'h13;
  localparam logic [7:0] ADDR_P2_HI = 8'h14;
  // field layout and reset values
  localparam int LED_LSB = 0;
  localparam int LED_W = 4;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] LED_OFF = 4'h0;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // compressed threshold: upper nibble exponent, lower nibble mantissa
  localparam int CMP_EXP_LSB = 4;
  localparam int CMP_MAN_SHIFT = 4;

  // one byte write from the serial front end
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } pth_wr_t;

  // one proximity result from the measurement datapath
  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } pth_result_t;
endpackage
`default_nettype wire

// >>> pth_cross.sv
// threshold crossing detector for one proximity channel
`timescale 1ns/1ps
`default_nettype none
module pth_cross (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // control
  input wire logic enable,
  input wire logic [15:0] threshold,
  // result stream
  input wire pth_pkg::pth_result_t result,
  // event
  output logic crossed
);
  logic above_r;
  logic seen_r;
  logic crossed_r;
  wire logic now_above;
  wire logic hit;

  // threshold is read live, so a half-written word is compared as it stands
  assign now_above = result.value > threshold;
  assign hit = enable && result.valid && seen_r && (now_above != above_r);
  assign crossed = crossed_r;

  // remember which side the last result fell on; first result only arms
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      above_r <= 1'b0;
      seen_r <= 1'b0;
      crossed_r <= 1'b0;
    end else begin
      crossed_r <= hit;
      if (result.valid) begin
        above_r <= now_above;
        seen_r <= enable;
      end
    end
  end
endmodule
`default_nettype wire

// >>> pth_regs.sv
// emitter-three current and proximity threshold register bank with crossing events
`timescale 1ns/1ps
`default_nettype none
module pth_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port from the serial bus front end
  input wire pth_pkg::pth_wr_t wr,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  // revision strap, from a pin
  input wire logic legacy_rev,
  // measurement datapath
  input wire logic meas_active,
  input wire logic compare_en,
  input wire pth_pkg::pth_result_t prox_chan1_result,
  input wire pth_pkg::pth_result_t prox_chan2_result,
  // emitter driver
  output logic [3:0] third_emitter_current_code,
  output logic third_emitter_on,
  // host interrupt events
  output logic prox_chan1_event,
  output logic prox_chan2_event
);
  logic [3:0] led3_r;
  logic [7:0] p1_lo_r;
  logic [7:0] p1_hi_r;
  logic [7:0] p2_lo_r;
  logic [7:0] p2_hi_r;
  logic legacy_s1_r;
  logic legacy_s2_r;
  logic [3:0] drive_r;
  logic [7:0] rd_data_r;
  wire logic [15:0] prox_chan1_threshold;
  wire logic [15:0] prox_chan2_threshold;
  wire logic [7:0] rd_nxt;
  wire logic hit_led3;
  wire logic hit_p1_lo;
  wire logic hit_p1_hi;
  wire logic hit_p2_lo;
  wire logic hit_p2_hi;

  // expand an 8-bit compressed threshold into the 16-bit compare word
  function automatic logic [15:0] expand_cmp(input logic [7:0] c);
    logic [3:0] e;
    logic [31:0] v;
    e = c[pth_pkg::CMP_EXP_LSB +: 4];
    v = ({27'h000_0000, 1'b1, c[3:0]} << e) >> pth_pkg::CMP_MAN_SHIFT;
    if (c == pth_pkg::RST_BYTE) begin
      expand_cmp = 16'h0000;
    end else if (v[31:16] != 16'h0000) begin
      expand_cmp = 16'hFFFF;
    end else begin
      expand_cmp = v[15:0];
    end
  endfunction

  // write address decode
  assign hit_led3 = wr.en && (wr.addr == pth_pkg::ADDR_LED3);
  assign hit_p1_lo = wr.en && (wr.addr == pth_pkg::ADDR_P1_LO);
  assign hit_p1_hi = wr.en && (wr.addr == pth_pkg::ADDR_P1_HI);
  assign hit_p2_lo = wr.en && (wr.addr == pth_pkg::ADDR_P2_LO);
  assign hit_p2_hi = wr.en && (wr.addr == pth_pkg::ADDR_P2_HI);

  // strap is asynchronous to the core, so two flops before use
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      legacy_s1_r <= 1'b0;
      legacy_s2_r <= 1'b0;
    end else begin
      legacy_s1_r <= legacy_rev;
      legacy_s2_r <= legacy_s1_r;
    end
  end

  // register storage; the host keeps the field zero on parts without emitter three
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      led3_r <= pth_pkg::LED_OFF;
      p1_lo_r <= pth_pkg::RST_BYTE;
      p1_hi_r <= pth_pkg::RST_BYTE;
      p2_lo_r <= pth_pkg::RST_BYTE;
      p2_hi_r <= pth_pkg::RST_BYTE;
    end else begin
      if (hit_led3) begin
        led3_r <= wr.data[pth_pkg::LED_LSB +: pth_pkg::LED_W];
      end
      if (hit_p1_lo) begin
        p1_lo_r <= wr.data;
      end
      if (hit_p1_hi) begin
        p1_hi_r <= wr.data;
      end
      if (hit_p2_lo) begin
        p2_lo_r <= wr.data;
      end
      if (hit_p2_hi) begin
        p2_hi_r <= wr.data;
      end
    end
  end

  // compare words: no shadow copy, each byte in use takes effect as soon as written; legacy mode uses only the low bytes
  assign prox_chan1_threshold = legacy_s2_r ? expand_cmp(p1_lo_r) : {p1_hi_r, p1_lo_r};
  assign prox_chan2_threshold = legacy_s2_r ? expand_cmp(p2_lo_r) : {p2_hi_r, p2_lo_r};

  // read mux; reserved upper nibble and unmapped offsets read zero
  assign rd_nxt = (rd_addr == pth_pkg::ADDR_LED3) ? {4'h0, led3_r} :
                  (rd_addr == pth_pkg::ADDR_P1_LO) ? p1_lo_r :
                  (rd_addr == pth_pkg::ADDR_P1_HI) ? p1_hi_r :
                  (rd_addr == pth_pkg::ADDR_P2_LO) ? p2_lo_r :
                  (rd_addr == pth_pkg::ADDR_P2_HI) ? p2_hi_r : pth_pkg::RD_UNMAPPED;

  // emitter sinks current only while a measurement runs; code zero means none
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      drive_r <= pth_pkg::LED_OFF;
      rd_data_r <= pth_pkg::RST_BYTE;
    end else begin
      drive_r <= meas_active ? led3_r : pth_pkg::LED_OFF;
      rd_data_r <= rd_nxt;
    end
  end

  assign third_emitter_current_code = drive_r;
  assign third_emitter_on = drive_r != pth_pkg::LED_OFF;
  assign rd_data = rd_data_r;

  // crossing detectors, one per channel
  pth_cross u_cross1 (
    .sys_clk(sys_clk),
    .rst(rst),
    .enable(compare_en),
    .threshold(prox_chan1_threshold),
    .result(prox_chan1_result),
    .crossed(prox_chan1_event)
  );

  pth_cross u_cross2 (
    .sys_clk(sys_clk),
    .rst(rst),
    .enable(compare_en),
    .threshold(prox_chan2_threshold),
    .result(prox_chan2_result),
    .crossed(prox_chan2_event)
  );
endmodule
`default_nettype wire

// >>> pth_chk.sv
// assertion checker for the threshold and emitter register bank
`timescale 1ns/1ps
`default_nettype none
module pth_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // watched ports
  input wire pth_pkg::pth_wr_t wr,
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic meas_active,
  input wire logic compare_en,
  input wire pth_pkg::pth_result_t prox_chan1_result,
  input wire logic [3:0] third_emitter_current_code,
  input wire logic third_emitter_on,
  input wire logic prox_chan1_event
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // a byte write, then a read of the same place with no write between
  sequence s_put(a);
    wr.en && wr.addr == a;
  endsequence
  property p_store(logic [7:0] a);
    logic [7:0] v;
    (s_put(a), v = wr.data) ##1 (rd_addr == a && !wr.en) |=> rd_data == v;
  endproperty
  chk_lo1_store: assert property (p_store(pth_pkg::ADDR_P1_LO)) else $error("lo1 lost");
  chk_hi1_store: assert property (p_store(pth_pkg::ADDR_P1_HI)) else $error("hi1 lost");
  chk_lo2_store: assert property (p_store(pth_pkg::ADDR_P2_LO)) else $error("lo2 lost");
  chk_led_rsvd: assert property ($past(rd_addr) == 8'h10 |-> rd_data[7:4] == 4'h0) else $error("rsvd");
  chk_emit_on: assert property (third_emitter_on == (third_emitter_current_code != 4'h0)) else $error("on");
  chk_emit_idle: assert property (!$past(meas_active) |-> third_emitter_current_code == 4'h0) else $error("idle");
  // while measuring, the drive code matches the stored code read back in the same cycle
  chk_emit_code: assert property ($past(meas_active) && $past(rd_addr) == pth_pkg::ADDR_LED3 |->
    third_emitter_current_code == rd_data[3:0]) else $error("code");
  chk_evt_gate: assert property ($past(!compare_en) |-> !prox_chan1_event) else $error("gate");
  chk_evt_cause: assert property (prox_chan1_event |-> $past(prox_chan1_result.valid)) else $error("cause");
endmodule
bind pth_regs pth_chk pth_chk_i (.sys_clk, .rst, .wr, .rd_addr, .rd_data, .meas_active, .compare_en,
  .prox_chan1_result, .third_emitter_current_code, .third_emitter_on, .prox_chan1_event);
`default_nettype wire

// >>> pth_host.sv
// host controller model that writes register bytes
`timescale 1ns/1ps
`default_nettype none
module pth_host #(parameter int EMITTERS = 3) (
  // clock and status
  input wire logic sys_clk,
  input wire logic meas_active,
  // write port
  output pth_pkg::pth_wr_t wr
);
  // write attempts that gave up waiting for the measurement to end
  int stalls = 0;
  initial wr = '0;
  // waits up to 64 cycles for a running measurement to end, then writes anyway
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    for (int n = 0; n < 64 && meas_active; n++) @(negedge sys_clk);
    if (meas_active) stalls++;
    if (a == pth_pkg::ADDR_LED3 && EMITTERS < 3) d[3:0] = 4'h0;
    @(negedge sys_clk) wr = '{1'b1, a, d};
    @(negedge sys_clk) wr.en = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> pth_regs_bench.sv
// self-checking bench for the threshold and emitter register bank
`timescale 1ns/1ps
`default_nettype none
module pth_regs_bench;
  logic sys_clk = 0, rst = 1, legacy_rev = 0, meas_active = 0, compare_en = 0;
  logic [7:0] rd_addr = 8'h00, rd_data;
  pth_pkg::pth_wr_t wr;
  pth_pkg::pth_result_t prox_chan1_result = '0, prox_chan2_result = '0;
  logic [3:0] third_emitter_current_code;
  logic third_emitter_on, prox_chan1_event, prox_chan2_event;
  int error_cnt = 0, compares = 0;
  pth_host pth_host_i (.sys_clk, .meas_active, .wr);
  pth_regs pth_regs_i (.sys_clk, .rst, .wr, .rd_addr, .rd_data, .legacy_rev, .meas_active, .compare_en,
    .prox_chan1_result, .prox_chan2_result, .third_emitter_current_code, .third_emitter_on,
    .prox_chan1_event, .prox_chan2_event);
  // core clock
  initial forever #5 sys_clk = ~sys_clk;
  task automatic end_of_test;
    error_cnt += pth_host_i.stalls;
    if (error_cnt == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // read data lands one edge after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk) rd_addr = a;
    @(negedge sys_clk) cmp(rd_data, exp);
  endtask
  // address set first so the byte is read back the cycle after it is stored
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    rd_addr = a;
    pth_host_i.put(a, d);
    rd(a, exp);
  endtask
  // one result pulse, then the event is due one edge later
  task automatic res(input bit ch, input logic [15:0] v, input logic ev);
    @(negedge sys_clk);
    if (ch) prox_chan2_result = '{1'b1, v};
    else prox_chan1_result = '{1'b1, v};
    @(negedge sys_clk);
    prox_chan1_result.valid = 1'b0;
    prox_chan2_result.valid = 1'b0;
    cmp(ch ? prox_chan2_event : prox_chan1_event, ev);
  endtask
  task automatic t_reset;
    for (logic [7:0] a = 8'h10; a < 8'h16; a++) rd(a, 8'h00);
  endtask
  task automatic t_regs;
    wr_rd(8'h10, 8'hff, 8'h0f);
    wr_rd(8'h11, 8'ha5, 8'ha5);
    wr_rd(8'h12, 8'h5a, 8'h5a);
    wr_rd(8'h13, 8'h3c, 8'h3c);
    wr_rd(8'h15, 8'h77, 8'h00);
  endtask
  task automatic t_emit;
    logic [3:0] c [3] = '{4'h0, 4'h1, 4'hf};
    rd_addr = 8'h10;
    foreach (c[i]) begin
      pth_host_i.put(8'h10, {4'h0, c[i]});
      meas_active = 1;
      repeat (2) @(negedge sys_clk);
      cmp(third_emitter_current_code, c[i]);
      cmp(third_emitter_on, c[i] != 4'h0);
      meas_active = 0;
      repeat (2) @(negedge sys_clk);
      cmp(third_emitter_current_code, 4'h0);
    end
  endtask
  task automatic t_cross;
    pth_host_i.put(8'h11, 8'h10);
    pth_host_i.put(8'h12, 8'h00);
    pth_host_i.put(8'h13, 8'h40);
    compare_en = 1;
    res(0, 16'h0005, 0);
    res(0, 16'h0020, 1);
    res(1, 16'h0010, 0);
    res(1, 16'h0050, 1);
    pth_host_i.put(8'h12, 8'h01);
    res(0, 16'h0030, 1);
    compare_en = 0;
    res(0, 16'h0200, 0);
  endtask
  // compressed byte 0x40: exponent 4, mantissa 0; the wide word would be 0x0140
  task automatic t_legacy;
    logic [15:0] thr;
    thr = (16'h0010 << 4) >> 4;
    legacy_rev = 1;
    pth_host_i.put(8'h11, 8'h40);
    compare_en = 1;
    res(0, thr - 16'h0001, 0);
    res(0, thr + 16'h0001, 1);
  endtask
  // second reset in mid-run must clear every written byte again
  task automatic t_rerst;
    compare_en = 0;
    rst = 1;
    repeat (2) @(negedge sys_clk);
    rst = 0;
    t_reset;
  endtask
  initial begin
    repeat (16) @(negedge sys_clk);
    rst = 0;
    t_reset;
    t_regs;
    t_emit;
    t_cross;
    t_legacy;
    t_rerst;
    end_of_test;
  end
  // cut a hung run short
  initial begin
    #100000;
    error_cnt++;
    end_of_test;
  end
endmodule
`default_nettype wire
